//--- inc/srm_pkg.sv
// Constants for the supply, reference and temperature monitor select block.
// Assumes byte-addressed Avalon-MM access with 32-bit data words.
package srm_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [4:0] SRM_OFS_CFG0 = 5'h00;
  localparam logic [4:0] SRM_OFS_CFG1 = 5'h04;
  localparam logic [4:0] SRM_OFS_CTRL = 5'h08;
  localparam logic [4:0] SRM_OFS_STAT = 5'h0c;
  localparam logic [4:0] SRM_OFS_DATA = 5'h10;
  localparam logic [4:0] SRM_OFS_EFF = 5'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  // Configuration register 0: input_select, gain, gain-stage bypass
  localparam int SRM_C0_BYP = 0;
  localparam int SRM_C0_GAIN_LO = 1;
  localparam int SRM_C0_GAIN_HI = 3;
  localparam int SRM_C0_SEL_LO = 4;
  localparam int SRM_C0_SEL_HI = 7;
  // Configuration register 1: temp_mode_bit, reference select
  localparam int SRM_C1_TS = 0;
  localparam int SRM_C1_REF_LO = 1;
  localparam int SRM_C1_REF_HI = 2;
  // Control: start strobe
  localparam int SRM_CT_START = 0;
  // Status: data ready, busy
  localparam int SRM_ST_DRDY = 0;
  localparam int SRM_ST_BUSY = 1;
  // Effective settings: bypass, gain, reference, temp, quarter, input sel
  localparam int SRM_EF_BYP = 0;
  localparam int SRM_EF_GAIN_LO = 1;
  localparam int SRM_EF_GAIN_HI = 3;
  localparam int SRM_EF_REF_LO = 4;
  localparam int SRM_EF_REF_HI = 5;
  localparam int SRM_EF_TEMP = 6;
  localparam int SRM_EF_QTR = 7;
  localparam int SRM_EF_SEL_LO = 8;
  localparam int SRM_EF_SEL_HI = 11;

  // ----------------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] SRM_SEL_SUPPLY = 4'hd;
  localparam logic [3:0] SRM_SEL_EXTREF = 4'hc;
  localparam logic [2:0] SRM_GAIN_UNITY = 3'h0;
  localparam logic [1:0] SRM_REF_INTERNAL = 2'h0;
  localparam logic [7:0] SRM_CFG0_RST = 8'h00;
  localparam logic [2:0] SRM_CFG1_RST = 3'h0;

  // Temperature weight per code step, in micro-degrees Celsius
  localparam int SRM_TEMP_LSB_UDEGC = 31250;

  typedef enum logic {SRM_IDLE, SRM_BUSY} srm_state_t;

endpackage : srm_pkg

//--- hw/srm_monitor_select.sv
// Monitor source selection and result formatting with Avalon-MM registers.
// Assumes an analog converter that takes the routing outputs, pulses
// conv_done with raw data, and a transport that takes bits on ser_*.
//
// Operation
// - Monitor source forces unity gain, bypass
// - Code 1101 routes supply, quarter scale
// - Supply monitor uses internal reference
// - Code 1100 routes reference pins, quarter
// - Reference monitor uses internal reference
// - temp_mode_bit selects temperature measurement
// - Temperature ignores register 0, internal reference
// - Temperature uses same start/readback path
// - 14-bit code left-justified in 24 bits
// - Result bytes sent least bit first
// - Code step weighs 0.03125 degrees
// - Negative temperatures in two's complement
`timescale 1ns/1ps
`default_nettype none

module srm_monitor_select
  import srm_pkg::*;
#(
  parameter int RESULT_W = 24,
  parameter int TEMP_W = 14
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [3:0] adc_input_select,
  output logic [2:0] adc_gain,
  output logic adc_gain_bypass,
  output logic [1:0] adc_ref_select,
  output logic adc_temp_en,
  output logic adc_quarter_scale,
  output logic adc_conv_start,
  input wire logic adc_conv_done,
  input wire logic [23:0] adc_raw_data,
  input wire logic [13:0] adc_temp_code,
  output logic ser_bit,
  output logic ser_valid,
  input wire logic ser_ready
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  localparam int PAD_W = RESULT_W - TEMP_W;

  generate
    if (RESULT_W != 24 || TEMP_W != 14) begin : g_bad_width
      $error("srm_monitor_select: widths must be 24 and 14");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle per access
  // ----------------------------------------------------------------------
  logic ack_q;
  logic acc;
  logic wr_take;
  logic rd_take;

  assign acc = avs_read | avs_write;
  // Low ce keeps the access waiting
  assign avs_waitrequest = acc & ~(ack_q & ce);
  assign wr_take = ce & avs_write & ack_q;
  assign rd_take = ce & avs_read & ack_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= acc & ~ack_q;
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic hit_cfg0;
  logic hit_cfg1;
  logic hit_ctrl;
  logic hit_data;

  assign hit_cfg0 = avs_address == SRM_OFS_CFG0;
  assign hit_cfg1 = avs_address == SRM_OFS_CFG1;
  assign hit_ctrl = avs_address == SRM_OFS_CTRL;
  assign hit_data = avs_address == SRM_OFS_DATA;

  // ----------------------------------------------------------------------
  // Host configuration
  // ----------------------------------------------------------------------
  logic [7:0] cfg0_q;
  logic [2:0] cfg1_q;
  logic start_cmd;

  assign start_cmd = wr_take && hit_ctrl
    && avs_byteenable[0] && avs_writedata[SRM_CT_START];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg0_q <= SRM_CFG0_RST;
    end else if (wr_take && avs_byteenable[0] && hit_cfg0) begin
      cfg0_q <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg1_q <= SRM_CFG1_RST;
    end else if (wr_take && avs_byteenable[0] && hit_cfg1) begin
      cfg1_q <= avs_writedata[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // Effective routing
  // ----------------------------------------------------------------------
  logic [3:0] sel_cfg;
  logic ts_cfg;
  logic is_supply;
  logic is_extref;
  logic is_monitor;
  logic [3:0] eff_sel;
  logic [2:0] eff_gain;
  logic eff_byp;
  logic [1:0] eff_ref;
  logic eff_qtr;

  assign sel_cfg = cfg0_q[SRM_C0_SEL_HI:SRM_C0_SEL_LO];
  assign ts_cfg = cfg1_q[SRM_C1_TS];
  assign is_supply = sel_cfg == SRM_SEL_SUPPLY;
  assign is_extref = sel_cfg == SRM_SEL_EXTREF;
  assign is_monitor = (is_supply | is_extref) & ~ts_cfg;

  always_comb begin
    eff_sel = sel_cfg;
    eff_gain = cfg0_q[SRM_C0_GAIN_HI:SRM_C0_GAIN_LO];
    eff_byp = cfg0_q[SRM_C0_BYP];
    eff_ref = cfg1_q[SRM_C1_REF_HI:SRM_C1_REF_LO];
    eff_qtr = 1'b0;
    if (ts_cfg) begin
      // Register 0 has no say in temperature mode
      eff_sel = 4'h0;
      eff_gain = SRM_GAIN_UNITY;
      eff_byp = 1'b1;
      eff_ref = SRM_REF_INTERNAL;
    end else if (is_monitor) begin
      eff_gain = SRM_GAIN_UNITY;
      eff_byp = 1'b1;
      eff_ref = SRM_REF_INTERNAL;
      eff_qtr = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequence, shared by all modes
  // ----------------------------------------------------------------------
  srm_state_t state_q;
  logic drdy_q;
  logic [RESULT_W-1:0] result_q;
  logic done_evt;

  assign done_evt = ce && state_q == SRM_BUSY && adc_conv_done;

  logic [RESULT_W-1:0] temp_word;
  assign temp_word = {adc_temp_code, {PAD_W{1'b0}}};

  // Settings held steady for the whole conversion
  logic latch_en;

  assign latch_en = start_cmd && state_q == SRM_IDLE;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adc_input_select <= 4'h0;
    end else if (latch_en) begin
      adc_input_select <= eff_sel;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adc_gain <= SRM_GAIN_UNITY;
    end else if (latch_en) begin
      adc_gain <= eff_gain;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adc_gain_bypass <= 1'b0;
    end else if (latch_en) begin
      adc_gain_bypass <= eff_byp;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adc_ref_select <= SRM_REF_INTERNAL;
    end else if (latch_en) begin
      adc_ref_select <= eff_ref;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adc_temp_en <= 1'b0;
    end else if (latch_en) begin
      adc_temp_en <= ts_cfg;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adc_quarter_scale <= 1'b0;
    end else if (latch_en) begin
      adc_quarter_scale <= eff_qtr;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adc_conv_start <= 1'b0;
    end else if (ce) begin
      adc_conv_start <= latch_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= SRM_IDLE;
    end else if (ce) begin
      unique case (state_q)
        SRM_IDLE: begin
          if (start_cmd) begin
            state_q <= SRM_BUSY;
          end
        end
        SRM_BUSY: begin
          if (adc_conv_done) begin
            state_q <= SRM_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      result_q <= '0;
    end else if (done_evt) begin
      if (adc_temp_en) begin
        // Signed code kept as is; low bits zero
        result_q <= temp_word;
      end else begin
        result_q <= adc_raw_data;
      end
    end
  end

  // Completion wins over a same-cycle read of the data word
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drdy_q <= 1'b0;
    end else if (done_evt) begin
      drdy_q <= 1'b1;
    end else if (rd_take && hit_data) begin
      drdy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Serial result output, least significant bit first
  // ----------------------------------------------------------------------
  localparam int CNT_W = $clog2(RESULT_W + 1);
  localparam logic [CNT_W-1:0] BITS_ALL = CNT_W'(RESULT_W);
  logic [RESULT_W-1:0] shift_q;
  logic [CNT_W-1:0] left_q;

  assign ser_valid = left_q != '0;
  assign ser_bit = shift_q[0];

  // A new result restarts the stream; slow takers lose the old word
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift_q <= '0;
    end else if (done_evt) begin
      shift_q <= adc_temp_en ? temp_word : adc_raw_data;
    end else if (ce && ser_valid && ser_ready) begin
      shift_q <= {1'b0, shift_q[RESULT_W-1:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      left_q <= '0;
    end else if (done_evt) begin
      left_q <= BITS_ALL;
    end else if (ce && ser_valid && ser_ready) begin
      left_q <= left_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && !ack_q) begin
      avs_readdata <= 32'h0000_0000;
      unique case (avs_address)
        SRM_OFS_CFG0: avs_readdata[7:0] <= cfg0_q;
        SRM_OFS_CFG1: avs_readdata[2:0] <= cfg1_q;
        SRM_OFS_STAT: begin
          avs_readdata[SRM_ST_DRDY] <= drdy_q;
          avs_readdata[SRM_ST_BUSY] <= state_q == SRM_BUSY;
        end
        SRM_OFS_DATA: avs_readdata[RESULT_W-1:0] <= result_q;
        SRM_OFS_EFF: begin
          avs_readdata[SRM_EF_BYP] <= adc_gain_bypass;
          avs_readdata[SRM_EF_GAIN_HI:SRM_EF_GAIN_LO] <= adc_gain;
          avs_readdata[SRM_EF_REF_HI:SRM_EF_REF_LO] <= adc_ref_select;
          avs_readdata[SRM_EF_TEMP] <= adc_temp_en;
          avs_readdata[SRM_EF_QTR] <= adc_quarter_scale;
          avs_readdata[SRM_EF_SEL_HI:SRM_EF_SEL_LO] <= adc_input_select;
        end
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : srm_monitor_select

`default_nettype wire

//--- test/srm_adc_model.sv
// Converter and serial sink model facing the monitor select block.
// Assumes the bench supplies the raw and temperature values to return.
`timescale 1ns/1ps
`default_nettype none
module srm_adc_model (
  input wire logic clk,
  input wire logic adc_conv_start,
  input wire logic ser_bit,
  input wire logic ser_valid,
  input wire logic [23:0] raw_val,
  input wire logic [13:0] code_val,
  output logic adc_conv_done = 1'b0,
  output logic [23:0] adc_raw_data = 24'h0,
  output logic [13:0] adc_temp_code = 14'h0,
  output logic ser_ready = 1'b0,
  output logic [23:0] rx_word = 24'h0,
  output int rx_cnt = 0
);
  int wait_n = 0;
  // ------------------------------
  // Conversion and bit capture
  // ------------------------------
  always @(posedge clk) begin
    ser_ready <= ($urandom % 4) != 0;
    adc_conv_done <= 1'b0;
    // Lines toggle outside done so stale data is never read
    adc_raw_data <= ~adc_raw_data;
    adc_temp_code <= ~adc_temp_code;
    if (adc_conv_start) begin
      wait_n <= 1 + $urandom % 8;
      rx_cnt <= 0;
    end else if (wait_n == 1) begin
      adc_conv_done <= 1'b1;
      adc_raw_data <= raw_val;
      adc_temp_code <= code_val;
      wait_n <= 0;
    end else if (wait_n > 1) begin
      wait_n <= wait_n - 1;
    end
    if (ser_valid && ser_ready && !adc_conv_start) begin
      rx_word <= {ser_bit, rx_word[23:1]};
      rx_cnt <= rx_cnt + 1;
    end
  end
endmodule : srm_adc_model
`default_nettype wire

//--- test/srm_monitor_select_properties.sv
// Port checker of the monitor select block.
// Assumes a bind onto srm_monitor_select.
`timescale 1ns/1ps
`default_nettype none
module srm_monitor_select_properties
  import srm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic [3:0] adc_input_select,
  input wire logic [2:0] adc_gain,
  input wire logic adc_gain_bypass,
  input wire logic [1:0] adc_ref_select,
  input wire logic adc_temp_en,
  input wire logic adc_quarter_scale,
  input wire logic adc_conv_start,
  input wire logic [23:0] adc_raw_data,
  input wire logic ser_bit,
  input wire logic ser_valid
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_supply_forced: assert property (
    adc_conv_start && !adc_temp_en && adc_input_select == 4'hd |->
    adc_gain == 3'h0 && adc_gain_bypass && adc_ref_select == 2'h0
  ) else $error("supply monitor settings not forced");
  a_extref_forced: assert property (
    adc_conv_start && !adc_temp_en && adc_input_select == 4'hc |->
    adc_gain == 3'h0 && adc_gain_bypass && adc_ref_select == 2'h0
  ) else $error("reference monitor settings not forced");
  a_quarter_scale: assert property (
    adc_conv_start |-> adc_quarter_scale ==
    (!adc_temp_en && adc_input_select[3:1] == 3'h6)
  ) else $error("quarter scale wrong");
  a_temp_ref: assert property (
    adc_temp_en |-> adc_ref_select == 2'h0 && adc_gain_bypass
  ) else $error("temperature mode reference wrong");
  a_temp_no_select: assert property (
    adc_temp_en |-> adc_input_select == 4'h0 && adc_gain == 3'h0
  ) else $error("temperature mode input not ignored");
  a_start_pulse: assert property (
    adc_conv_start |=> !adc_conv_start
  ) else $error("start pulse too long");
  a_one_wait: assert property (
    ce && $rose(avs_read) ##1 ce |-> $past(avs_waitrequest) && !avs_waitrequest
  ) else $error("read wait not one cycle");
  a_serial_lsb: assert property (
    $rose(ser_valid) |->
    ser_bit == ($past(adc_temp_en) ? 1'b0 : $past(adc_raw_data[0]))
  ) else $error("first serial bit wrong");
endmodule : srm_monitor_select_properties
bind srm_monitor_select srm_monitor_select_properties i_props (
  .clk(clk),
  .reset_n(reset_n),
  .ce(ce),
  .avs_read(avs_read),
  .avs_waitrequest(avs_waitrequest),
  .adc_input_select(adc_input_select),
  .adc_gain(adc_gain),
  .adc_gain_bypass(adc_gain_bypass),
  .adc_ref_select(adc_ref_select),
  .adc_temp_en(adc_temp_en),
  .adc_quarter_scale(adc_quarter_scale),
  .adc_conv_start(adc_conv_start),
  .adc_raw_data(adc_raw_data),
  .ser_bit(ser_bit),
  .ser_valid(ser_valid)
);
`default_nettype wire

//--- test/test_supply_ref_temp_monitor_select.sv
// Bench of the monitor select block over its register bus.
// Assumes the converter model answers every start.
`timescale 1ns/1ps
`default_nettype none
module test_supply_ref_temp_monitor_select
  import srm_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1, avs_read = 1'b0;
  logic avs_write = 1'b0, avs_waitrequest, adc_gain_bypass, adc_temp_en;
  logic adc_quarter_scale, adc_conv_start, ser_bit, ser_valid, ser_ready;
  logic adc_conv_done, ts, byp;
  logic [4:0] avs_address = 5'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf, adc_input_select, sel;
  logic [2:0] adc_gain, gain;
  logic [1:0] adc_ref_select, rf;
  logic [23:0] adc_raw_data, rx_word, raw_val = 24'h0, exp_res;
  logic [13:0] adc_temp_code, code_val = 14'h0;
  int rx_cnt, err_count = 0, check_count = 0, cyc = 0, n;
  srm_monitor_select i_srm_monitor_select (
    .clk(clk), .reset_n(reset_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .adc_input_select(adc_input_select), .adc_gain(adc_gain),
    .adc_gain_bypass(adc_gain_bypass), .adc_ref_select(adc_ref_select),
    .adc_temp_en(adc_temp_en), .adc_quarter_scale(adc_quarter_scale),
    .adc_conv_start(adc_conv_start), .adc_conv_done(adc_conv_done),
    .adc_raw_data(adc_raw_data), .adc_temp_code(adc_temp_code),
    .ser_bit(ser_bit), .ser_valid(ser_valid), .ser_ready(ser_ready));
  srm_adc_model i_srm_adc_model (
    .clk(clk), .adc_conv_start(adc_conv_start), .ser_bit(ser_bit),
    .ser_valid(ser_valid), .raw_val(raw_val), .code_val(code_val),
    .adc_conv_done(adc_conv_done), .adc_raw_data(adc_raw_data),
    .adc_temp_code(adc_temp_code), .ser_ready(ser_ready),
    .rx_word(rx_word), .rx_cnt(rx_cnt));
  always #10 clk = ~clk;
  always @(posedge clk) if (++cyc > 20000) begin err_count++; stop_test(); end
  // ------------------------------
  // Helpers
  // ------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  function automatic logic [11:0] exp_eff(input logic [3:0] s,
    input logic [2:0] g, input logic b, input logic [1:0] r, input logic t);
    if (t) return {4'h0, 2'h1, SRM_REF_INTERNAL, SRM_GAIN_UNITY, 1'b1};
    if (s == SRM_SEL_SUPPLY || s == SRM_SEL_EXTREF)
      return {s, 2'h2, SRM_REF_INTERNAL, SRM_GAIN_UNITY, 1'b1};
    return {s, 2'h0, r, g, b};
  endfunction : exp_eff
  task stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    n = $urandom(32'h53a3bb77);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b0, 5'h18, 32'h0);
    chk(q, 32'h0, "unmapped");
    for (int i = 0; i < 14; i++) begin
      sel = (i == 0) ? 4'hd : (i == 1) ? 4'hc : 4'($urandom);
      {gain, byp, rf} = 6'($urandom);
      ts = (i == 2) || (i > 6 && $urandom % 2);
      raw_val <= 24'($urandom);
      code_val <= (i == 2) ? 14'h3ff8 : 14'($urandom);
      bus(1'b1, SRM_OFS_CFG0, {24'h0, sel, gain, byp});
      bus(1'b1, SRM_OFS_CFG1, {29'h0, rf, ts});
      bus(1'b1, SRM_OFS_CTRL, 32'h1);
      n = 0;
      do begin bus(1'b0, SRM_OFS_STAT, 32'h0); n++; end
      while (q[0] !== 1'b1 && n < 40);
      exp_res = ts ? {code_val, 10'h0} : raw_val;
      bus(1'b0, SRM_OFS_DATA, 32'h0);
      chk(q, {8'h0, exp_res}, "result");
      if (i == 2)
        chk($signed(q[23:10]) * SRM_TEMP_LSB_UDEGC, -250000, "neg");
      bus(1'b0, SRM_OFS_EFF, 32'h0);
      chk(q, {20'h0, exp_eff(sel, gain, byp, rf, ts)},
        "settings");
      n = 0;
      while (rx_cnt != 24 && n < 300) begin @(posedge clk); n++; end
      chk({8'h0, rx_word}, {8'h0, exp_res}, "serial");
      $display("test %0d done", i);
    end
    stop_test();
  end
endmodule : test_supply_ref_temp_monitor_select
`default_nettype wire
